// >>> hdl/wrps_top.sv
// resource power sequencer with power state decode and register port
// What this block does
// - each resource is enabled, disabled, ramping up or ramping down
// - resource timer is zero when settled, nonzero while ramping
// - turn-on loads enable delay, turn-off loads disable delay
// - timers and counters step once per sleep oscillator tick
// - timer reaching zero completes the ramp to enabled or disabled
// - zero enable delay goes straight from disabled to enabled
// - zero disable delay goes straight from enabled to disabled
// - required set joins clock requests, minimum mask and request timer
// - each core clock request maps to the resources making that clock
// - first, required set is closed over the dependency table
// - second, nonzero timers decrement; at zero clear pending, flip on flag
// - third, required set is compared with current resource status
// - fourth, unrequested enabled resources without live dependents turn off
// - fifth, requested disabled resources with all dependencies on turn on
// - sleep stops main clocks; only the sequencer keeps its sleep clock
// - both pins low: full power-down, or shutdown with bandgap and io regulator
// - either pin high by the host leaves the power-down states
// - external mode turns on only the core switching regulator
// - out of reset core regulators are on; all off only in reset
// - low ripple pin with supply request selects pwm, else burst unless the control bit sets pwm out of reset
// - shutdown holds the core in reset with pins tristated
// - leaving shutdown is a fresh power-up with no state kept
`timescale 1ns/1ps
module wrps_top #(
    parameter logic [wrps_pkg::NRES*wrps_pkg::TW-1:0]   ON_DELAY  = wrps_pkg::ON_DELAY_DEF,
    parameter logic [wrps_pkg::NRES*wrps_pkg::TW-1:0]   OFF_DELAY = wrps_pkg::OFF_DELAY_DEF,
    parameter logic [wrps_pkg::NRES*wrps_pkg::NRES-1:0] DEP_TABLE = wrps_pkg::DEP_DEF
) (
    input  wire logic                          clk,          // 200 MHz system clock
    input  wire logic                          sys_rst,      // synchronous reset
    input  wire logic                          sleep_clk,    // 32.768 kHz sleep oscillator pin
    input  wire wrps_pkg::wrps_pins_t          pins,         // host power pins, asynchronous
    input  wire logic [wrps_pkg::NCLK-1:0]     clk_req,      // core clock requests
    input  wire logic [7:0]                    addr,         // register byte address
    input  wire logic [31:0]                   wdata,        // register write data
    input  wire logic                          we,           // write strobe
    input  wire logic                          re,           // read strobe
    output logic      [31:0]                   rdata,        // read data, cycle after re
    output wrps_pkg::wrps_regen_t              reg_en,       // regulator enables
    output logic                               buck_pwm,     // 1 pwm, 0 burst
    output logic                               core_rst_n,   // wlan core reset, low active
    output logic                               io_tristate,  // pins tristated, inputs off
    output logic                               main_clk_en,  // main clocks running
    output wrps_pkg::wrps_pstate_t             pstate        // chip power state
);
    localparam int NR = wrps_pkg::NRES;
    localparam int TW = wrps_pkg::TW;

    logic [4:0]            sync1_r;
    logic [4:0]            sync2_r;
    logic                  slp_q_r;
    wrps_pkg::wrps_pins_t  pins_s;
    wire                   tick;
    wire                   run;

    logic [NR-1:0]         min_r;
    logic [TW-1:0]         rt_cnt_r;
    logic [NR-1:0]         rt_mask_r;
    logic                  int_pwm_r;
    logic [NR-1:0]         on_r;
    logic [NR-1:0]         pend_r;
    logic [TW-1:0]         tmr_r [NR];
    logic [NR-1:0]         on_a;
    logic [NR-1:0]         pend_a;
    logic [NR-1:0]         on_nxt;
    logic [NR-1:0]         pend_nxt;
    logic [TW-1:0]         tmr_nxt [NR];
    logic [TW-1:0]         tmr_dec [NR];
    logic [31:0]           rdata_r;
    wrps_pkg::wrps_pstate_t pstate_r;
    wrps_pkg::wrps_pstate_t pstate_nxt;
    wrps_pkg::wrps_regen_t  regen_r;
    logic [wrps_pkg::NREG-1:0] regen_nxt;
    logic                  buck_pwm_r;
    logic                  core_rst_n_r;
    logic                  io_tri_r;
    logic                  main_clk_r;

    // the first stage is read only by the second; edge detect sits behind both
    always_ff @(posedge clk) begin
        sync1_r <= {sleep_clk, pins};
        sync2_r <= sync1_r;
        slp_q_r <= sync2_r[4];
    end

    assign pins_s = wrps_pkg::wrps_pins_t'(sync2_r[3:0]);
    assign tick   = sync2_r[4] & ~slp_q_r;
    assign run    = pins_s.wlan_reset_n;

    function automatic logic [NR-1:0] close_deps(input logic [NR-1:0] v);
        logic [NR-1:0] r;
        r = v;
        for (int n = 0; n < NR; n++) begin
            for (int i = 0; i < NR; i++) begin
                if (r[i]) begin
                    r = r | DEP_TABLE[i*NR +: NR];
                end
            end
        end
        return r;
    endfunction

    function automatic logic [NR-1:0] dependents(input int idx);
        logic [NR-1:0] c;
        c = '0;
        for (int j = 0; j < NR; j++) begin
            c[j] = DEP_TABLE[j*NR + idx];
        end
        return c;
    endfunction

    function automatic logic [NR-1:0] clk_set(input logic [wrps_pkg::NCLK-1:0] q);
        logic [NR-1:0] s;
        s = '0;
        for (int k = 0; k < wrps_pkg::NCLK; k++) begin
            if (q[k]) begin
                s = s | wrps_pkg::CLK_MAP[k*NR +: NR];
            end
        end
        return s;
    endfunction

    // required set: union of all requests, closed over dependencies
    wire [NR-1:0] rt_req  = (rt_cnt_r != '0) ? rt_mask_r : '0;
    wire [NR-1:0] req_raw = clk_set(clk_req) | min_r | rt_req | wrps_pkg::FORCE_ON;
    wire [NR-1:0] req     = close_deps(req_raw);
    wire [NR-1:0] live_a  = on_a | pend_a;
    wire [NR-1:0] ready_a = on_a & ~pend_a;

    genvar g;
    generate
        for (g = 0; g < NR; g++) begin : g_res
            wire [TW-1:0] ond  = ON_DELAY[g*TW +: TW];
            wire [TW-1:0] offd = OFF_DELAY[g*TW +: TW];
            wire [NR-1:0] deps = DEP_TABLE[g*NR +: NR];
            wire          dec  = pend_r[g] & (tmr_r[g] != '0);
            wire          done = dec & (tmr_r[g] == TW'(1));
            // on and pend together encode the four resource states
            wire          dn   = on_a[g] & ~pend_a[g] & ~req[g]
                                 & ((live_a & dependents(g)) == '0);
            wire          up   = ~on_a[g] & ~pend_a[g] & req[g]
                                 & ((ready_a & deps) == deps);

            assign tmr_dec[g] = dec ? tmr_r[g] - TW'(1) : tmr_r[g];
            assign on_a[g]    = on_r[g] ^ done;
            assign pend_a[g]  = pend_r[g] & ~done;
            assign on_nxt[g]  = dn ? (offd != '0) : up ? (ond == '0) : on_a[g];
            assign pend_nxt[g] = dn ? (offd != '0) : up ? (ond != '0) : pend_a[g];
            assign tmr_nxt[g] = dn ? offd : up ? ond : tmr_dec[g];

            // a power-down clears everything so the next wake is a fresh start
            always_ff @(posedge clk) begin
                if (sys_rst || !run) begin
                    tmr_r[g] <= '0;
                end else if (tick) begin
                    tmr_r[g] <= tmr_nxt[g];
                end
            end

            a_timer_zero: assert property (@(posedge clk) disable iff (sys_rst)
                pend_r[g] == (tmr_r[g] != '0))
                else $error("timer and pending flag disagree");
            a_timer_load: assert property (@(posedge clk) disable iff (sys_rst)
                $rose(pend_r[g]) |-> tmr_r[g] == (on_r[g] ? offd : ond))
                else $error("ramp started without its delay");
            a_timer_step: assert property (@(posedge clk) disable iff (sys_rst)
                run && tick && pend_r[g] && tmr_r[g] > TW'(1)
                |=> tmr_r[g] == $past(tmr_r[g]) - TW'(1))
                else $error("timer did not step by one");
            a_timer_hold: assert property (@(posedge clk) disable iff (sys_rst)
                run && !tick |=> tmr_r[g] == $past(tmr_r[g]) && on_r == $past(on_r))
                else $error("sequencer moved without a sleep tick");
            a_ramp_done: assert property (@(posedge clk) disable iff (sys_rst)
                run && tick && pend_r[g] && tmr_r[g] == TW'(1)
                |=> on_r[g] != $past(on_r[g]))
                else $error("ramp end did not flip the on flag");
            a_up_deps: assert property (@(posedge clk) disable iff (sys_rst)
                !on_r[g] && !pend_r[g] ##1 (on_r[g] || pend_r[g])
                |-> (on_r & ~pend_r & deps) == deps)
                else $error("turn-on started before its dependencies");
            a_down_deps: assert property (@(posedge clk) disable iff (sys_rst)
                run && on_r[g] && !pend_r[g] ##1 run && (pend_r[g] || !on_r[g])
                |-> ((on_r | pend_r) & dependents(g)) == '0)
                else $error("turn-off started with a live dependent");
            if (ON_DELAY[g*TW +: TW] == '0) begin : g_ion
                a_on_direct: assert property (@(posedge clk) disable iff (sys_rst)
                    !(pend_r[g] && !on_r[g]))
                    else $error("zero enable delay entered ramp up");
            end
            if (OFF_DELAY[g*TW +: TW] == '0) begin : g_ioff
                a_off_direct: assert property (@(posedge clk) disable iff (sys_rst)
                    !(pend_r[g] && on_r[g]))
                    else $error("zero disable delay entered ramp down");
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst || !run) begin
            on_r   <= '0;
            pend_r <= '0;
        end else if (tick) begin
            on_r   <= on_nxt;
            pend_r <= pend_nxt;
        end
    end

    // register port
    wire wr_min  = we && (addr == wrps_pkg::A_MIN);
    wire wr_rtmr = we && (addr == wrps_pkg::A_RTMR);
    wire wr_ctrl = we && (addr == wrps_pkg::A_CTRL);

    always_ff @(posedge clk) begin
        if (sys_rst || !run) begin
            min_r     <= wrps_pkg::MIN_RST;
            rt_cnt_r  <= '0;
            rt_mask_r <= '0;
            int_pwm_r <= 1'b0;
        end else begin
            if (wr_min) begin
                min_r <= wdata[NR-1:0];
            end
            if (wr_ctrl) begin
                int_pwm_r <= wdata[wrps_pkg::CTRL_PWM_BIT];
            end
            // a write restarts the request timer even on a tick
            if (wr_rtmr) begin
                rt_cnt_r  <= wdata[TW-1:0];
                rt_mask_r <= wdata[wrps_pkg::RT_MASK_LSB +: NR];
            end else if (tick && rt_cnt_r != '0) begin
                rt_cnt_r <= rt_cnt_r - TW'(1);
            end
        end
    end

    // the request timer only moves on a sleep tick, a write aside
    a_rt_hold: assert property (@(posedge clk) disable iff (sys_rst)
        run && !tick && !wr_rtmr |=> rt_cnt_r == $past(rt_cnt_r))
        else $error("request timer moved without a sleep tick");
    a_rt_step: assert property (@(posedge clk) disable iff (sys_rst)
        run && tick && !wr_rtmr && rt_cnt_r != '0 |=> rt_cnt_r == $past(rt_cnt_r) - TW'(1))
        else $error("request timer did not step by one");

    wire [31:0] rd_mux =
        (addr == wrps_pkg::A_MIN)  ? 32'(min_r) :
        (addr == wrps_pkg::A_ON)   ? 32'(on_r) :
        (addr == wrps_pkg::A_PEND) ? 32'(pend_r) :
        (addr == wrps_pkg::A_RTMR) ? 32'({rt_mask_r, rt_cnt_r}) :
        (addr == wrps_pkg::A_CTRL) ? 32'(int_pwm_r) :
        (addr == wrps_pkg::A_STAT) ? 32'(pstate_r) : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= re ? rd_mux : '0;
        end
    end

    // power state decode
    wire clk_ok = on_r[wrps_pkg::R_XTAL] & ~pend_r[wrps_pkg::R_XTAL];
    wire [NR-1:0] en_vec = on_r ^ pend_r;

    assign pstate_nxt =
        (!run && !pins_s.external_supply_request) ?
            (pins_s.io_supply ? wrps_pkg::PS_SHUT : wrps_pkg::PS_OFF) :
        !run   ? wrps_pkg::PS_EXT :
        clk_ok ? wrps_pkg::PS_ACTIVE : wrps_pkg::PS_SLEEP;

    always_comb begin
        unique case (pstate_nxt)
            wrps_pkg::PS_OFF:    regen_nxt = '0;
            wrps_pkg::PS_SHUT:   regen_nxt = wrps_pkg::SHUT_SET;
            wrps_pkg::PS_EXT:    regen_nxt = wrps_pkg::EXT_SET;
            wrps_pkg::PS_SLEEP,
            wrps_pkg::PS_ACTIVE: regen_nxt = en_vec[wrps_pkg::NREG-1:0]
                                             | wrps_pkg::FORCE_RG;
            default:             regen_nxt = '0;
        endcase
    end

    // pwm whenever the host asks through the pin with supply requested
    wire buck_pwm_nxt = (pins_s.external_supply_request & pins_s.buck_lowripple_request)
                        | (run & int_pwm_r);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pstate_r     <= wrps_pkg::PS_OFF;
            regen_r      <= '0;
            buck_pwm_r   <= 1'b0;
            core_rst_n_r <= 1'b0;
            io_tri_r     <= 1'b1;
            main_clk_r   <= 1'b0;
        end else begin
            pstate_r     <= pstate_nxt;
            regen_r      <= wrps_pkg::wrps_regen_t'(regen_nxt);
            buck_pwm_r   <= buck_pwm_nxt;
            core_rst_n_r <= run;
            io_tri_r     <= ~run;
            main_clk_r   <= run & clk_ok;
        end
    end

    a_ext_only: assert property (@(posedge clk) disable iff (sys_rst)
        pstate_r == wrps_pkg::PS_EXT |-> regen_r == wrps_pkg::EXT_SET && !core_rst_n_r)
        else $error("external mode enabled more than the switching regulator");
    a_shut_regs: assert property (@(posedge clk) disable iff (sys_rst)
        pstate_r == wrps_pkg::PS_SHUT |-> regen_r == wrps_pkg::SHUT_SET && io_tri_r)
        else $error("shutdown regulator set wrong");
    a_core_regs: assert property (@(posedge clk) disable iff (sys_rst)
        core_rst_n_r |-> regen_r.core_switching_regulator && regen_r.core_linear_regulator)
        else $error("core regulators off out of reset");
    a_fresh_wake: assert property (@(posedge clk) disable iff (sys_rst)
        !run |=> on_r == '0 && pend_r == '0 && min_r == wrps_pkg::MIN_RST)
        else $error("state kept across power-down");

    // pin driven modes must follow the synchronised pins one cycle later
    a_pwm_pin: assert property (@(posedge clk) disable iff (sys_rst)
        pins_s.external_supply_request && pins_s.buck_lowripple_request |=> buck_pwm_r)
        else $error("low ripple pin did not select pwm");
    a_burst_pin: assert property (@(posedge clk) disable iff (sys_rst)
        !run && !pins_s.buck_lowripple_request |=> !buck_pwm_r)
        else $error("burst not selected in external mode");
    a_wake_pins: assert property (@(posedge clk) disable iff (sys_rst)
        run || pins_s.external_supply_request
        |=> pstate_r != wrps_pkg::PS_OFF && pstate_r != wrps_pkg::PS_SHUT)
        else $error("power-down kept with a wake pin high");
    a_off_regs: assert property (@(posedge clk) disable iff (sys_rst)
        pstate_r == wrps_pkg::PS_OFF |-> regen_r == '0 && !core_rst_n_r)
        else $error("regulator on in full power-down");
    a_main_clks: assert property (@(posedge clk) disable iff (sys_rst)
        main_clk_r == (pstate_r == wrps_pkg::PS_ACTIVE))
        else $error("main clocks running outside active mode");
    a_io_tristate: assert property (@(posedge clk) disable iff (sys_rst)
        io_tri_r == !core_rst_n_r)
        else $error("pins driven while the core is held in reset");

    assign rdata       = rdata_r;
    assign reg_en      = regen_r;
    assign buck_pwm    = buck_pwm_r;
    assign core_rst_n  = core_rst_n_r;
    assign io_tristate = io_tri_r;
    assign main_clk_en = main_clk_r;
    assign pstate      = pstate_r;
endmodule // wrps_top

// >>> hdl/wrps_pkg.sv
// shared constants and types of the wlan resource power sequencer
package wrps_pkg;
    localparam int NRES = 6;
    localparam int TW   = 8;
    localparam int NCLK = 2;
    localparam int NREG = 5;

    // resource indices; the first NREG are regulators
    localparam int R_BG    = 0;
    localparam int R_IOLDO = 1;
    localparam int R_CORE_SWITCHING_REGULATOR = 2;
    localparam int R_CORE_LINEAR_REGULATOR  = 3;
    localparam int R_LNLDO = 4;
    localparam int R_XTAL  = 5;

    localparam logic [7:0] A_MIN  = 8'h00;
    localparam logic [7:0] A_ON   = 8'h04;
    localparam logic [7:0] A_PEND = 8'h08;
    localparam logic [7:0] A_RTMR = 8'h0c;
    localparam logic [7:0] A_CTRL = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;

    localparam int RT_MASK_LSB  = 8;
    localparam int CTRL_PWM_BIT = 0;

    localparam logic [NRES-1:0] MIN_RST  = 6'h0f;
    localparam logic [NRES-1:0] FORCE_ON = 6'h0c;
    localparam logic [NREG-1:0] SHUT_SET = 5'h03;
    localparam logic [NREG-1:0] EXT_SET  = 5'h04;
    localparam logic [NREG-1:0] FORCE_RG = 5'h0c;

    // slot i holds the resources that resource i depends on
    localparam logic [NRES*NRES-1:0] DEP_DEF =
        {6'h08, 6'h04, 6'h04, 6'h01, 6'h01, 6'h00};
    localparam logic [NRES*TW-1:0] ON_DELAY_DEF =
        {8'h10, 8'h04, 8'h08, 8'h08, 8'h04, 8'h00};
    localparam logic [NRES*TW-1:0] OFF_DELAY_DEF =
        {8'h00, 8'h00, 8'h02, 8'h02, 8'h01, 8'h00};
    // slot k holds the resources that core clock request k needs
    localparam logic [NCLK*NRES-1:0] CLK_MAP = {6'h20, 6'h08};

    typedef enum logic [4:0] {
        PS_OFF    = 5'h01,
        PS_SHUT   = 5'h02,
        PS_EXT    = 5'h04,
        PS_SLEEP  = 5'h08,
        PS_ACTIVE = 5'h10
    } wrps_pstate_t;

    typedef struct packed {
        logic io_supply;
        logic buck_lowripple_request;
        logic external_supply_request;
        logic wlan_reset_n;
    } wrps_pins_t;

    typedef struct packed {
        logic lownoise_linear_regulator;
        logic core_linear_regulator;
        logic core_switching_regulator;
        logic io_linear_regulator;
        logic bandgap;
    } wrps_regen_t;
endpackage

// >>> verification/wrps_host.sv
// host side model: power pins and a free running sleep oscillator
`timescale 1ns/1ps
module wrps_host #(
    parameter real SLP_HALF = 100.3 // sped up far beyond 32.768 kHz to keep runs short
) (
    input  wire logic         clk,       // system clock, pins change after its edge
    output wrps_pkg::wrps_pins_t pins,   // reset, supply request, low ripple, io supply
    output logic              sleep_clk  // sleep oscillator, runs free
);
    initial begin
        pins      = '0;
        sleep_clk = 1'b0;
        forever #(SLP_HALF) sleep_clk = ~sleep_clk;
    end
    // rst_n or ext high takes the chip out of power-down
    task automatic drive(input logic rst_n, input logic ext, input logic lr, input logic io);
        @(posedge clk);
        pins <= '{io_supply: io, buck_lowripple_request: lr,
                  external_supply_request: ext, wlan_reset_n: rst_n};
    endtask
endmodule // wrps_host

// >>> verification/testbench.sv
// register and power state sequence tests of the resource power sequencer
`timescale 1ns/1ps
module testbench;
    logic                      clk;
    logic                      sys_rst;
    logic                      sleep_clk;
    wrps_pkg::wrps_pins_t      pins;
    logic [wrps_pkg::NCLK-1:0] clk_req;
    logic [7:0]                addr;
    logic [31:0]               wdata;
    logic                      we;
    logic                      re;
    logic [31:0]               rdata;
    wrps_pkg::wrps_regen_t     reg_en;
    logic                      buck_pwm;
    logic                      core_rst_n;
    logic                      io_tristate;
    logic                      main_clk_en;
    wrps_pkg::wrps_pstate_t    pstate;
    int                        num_errors;
    int                        compares;
    int                        cyc;
    logic [31:0]               d;

    wrps_host wrps_host_i (.clk(clk), .pins(pins), .sleep_clk(sleep_clk));
    wrps_top wrps_top_i (
        .clk(clk), .sys_rst(sys_rst), .sleep_clk(sleep_clk), .pins(pins),
        .clk_req(clk_req), .addr(addr), .wdata(wdata), .we(we), .re(re),
        .rdata(rdata), .reg_en(reg_en), .buck_pwm(buck_pwm), .core_rst_n(core_rst_n),
        .io_tristate(io_tristate), .main_clk_en(main_clk_en), .pstate(pstate));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // the whole sequence needs well under 20k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        we    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        we <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        re   <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1 v = rdata;
    endtask

    // bounded wait for a register to reach a value, then compare it
    task automatic poll(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        int          n;
        for (n = 0; n < 2000; n++) begin
            rd(a, v);
            if (v === exp) break;
        end
        chk(v, exp);
    endtask

    task automatic pins_set(input logic rst_n, input logic ext, input logic lr, input logic io);
        wrps_host_i.drive(rst_n, ext, lr, io);
        repeat (6) @(posedge clk);
        #1;
    endtask

    initial begin
        num_errors = 0;
        compares   = 0;
        cyc        = 0;
        sys_rst    = 1'b1;
        clk_req    = '0;
        addr       = '0;
        wdata      = '0;
        we         = 1'b0;
        re         = 1'b0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        pins_set(1'b0, 1'b0, 1'b0, 1'b0);
        chk(pstate, wrps_pkg::PS_OFF);
        chk(reg_en, 5'h00);
        pins_set(1'b0, 1'b0, 1'b0, 1'b1);
        chk(pstate, wrps_pkg::PS_SHUT);
        chk(reg_en, wrps_pkg::SHUT_SET);
        chk({core_rst_n, io_tristate}, 2'h1);
        pins_set(1'b0, 1'b1, 1'b1, 1'b1);
        chk(pstate, wrps_pkg::PS_EXT);
        chk(reg_en, wrps_pkg::EXT_SET);
        chk(buck_pwm, 1'b1);
        pins_set(1'b0, 1'b1, 1'b0, 1'b1);
        chk(buck_pwm, 1'b0);
        pins_set(1'b1, 1'b0, 1'b0, 1'b1);
        chk({core_rst_n, io_tristate}, 2'h2);
        chk(reg_en & wrps_pkg::FORCE_RG, wrps_pkg::FORCE_RG);
        rd(wrps_pkg::A_MIN, d);
        chk(d, 32'h0000000f);
        rd(8'h1c, d);
        chk(d, 32'h00000000);
        poll(wrps_pkg::A_ON, 32'h0000000f);
        rd(wrps_pkg::A_PEND, d);
        chk(d, 32'h00000000);
        chk(pstate, wrps_pkg::PS_SLEEP);
        chk(main_clk_en, 1'b0);
        chk(reg_en, 5'h0f);
        wr(wrps_pkg::A_CTRL, 32'h00000001);
        repeat (2) @(posedge clk);
        #1;
        chk(buck_pwm, 1'b1);
        wr(wrps_pkg::A_CTRL, 32'h00000000);
        repeat (2) @(posedge clk);
        #1;
        chk(buck_pwm, 1'b0);
        // low noise regulator ramps up over its delay, then down
        wr(wrps_pkg::A_MIN, 32'h0000001f);
        poll(wrps_pkg::A_PEND, 32'h00000010);
        rd(wrps_pkg::A_ON, d);
        chk(d, 32'h0000000f);
        poll(wrps_pkg::A_ON, 32'h0000001f);
        chk(reg_en, 5'h1f);
        // low noise has no disable delay and drops at once; io ramps down one tick
        wr(wrps_pkg::A_MIN, 32'h0000000d);
        poll(wrps_pkg::A_PEND, 32'h00000002);
        rd(wrps_pkg::A_ON, d);
        chk(d, 32'h0000000f);
        chk(reg_en, 5'h0d);
        poll(wrps_pkg::A_ON, 32'h0000000d);
        rd(wrps_pkg::A_PEND, d);
        chk(d, 32'h00000000);
        wr(wrps_pkg::A_MIN, 32'h0000000f);
        poll(wrps_pkg::A_ON, 32'h0000000f);
        // request timer holds the low noise regulator up while it counts
        wr(wrps_pkg::A_RTMR, 32'h00001020);
        poll(wrps_pkg::A_ON, 32'h0000001f);
        poll(wrps_pkg::A_ON, 32'h0000000f);
        @(posedge clk);
        clk_req <= 2'h2;
        poll(wrps_pkg::A_ON, 32'h0000002f);
        #1;
        chk(pstate, wrps_pkg::PS_ACTIVE);
        chk(main_clk_en, 1'b1);
        rd(wrps_pkg::A_STAT, d);
        chk(d, 32'h00000010);
        @(posedge clk);
        clk_req <= 2'h0;
        poll(wrps_pkg::A_ON, 32'h0000000f);
        // shutdown forgets all software state
        wr(wrps_pkg::A_MIN, 32'h0000003f);
        rd(wrps_pkg::A_MIN, d);
        chk(d, 32'h0000003f);
        pins_set(1'b0, 1'b0, 1'b0, 1'b1);
        chk(pstate, wrps_pkg::PS_SHUT);
        pins_set(1'b1, 1'b0, 1'b0, 1'b1);
        rd(wrps_pkg::A_MIN, d);
        chk(d, 32'h0000000f);
        poll(wrps_pkg::A_ON, 32'h0000000f);
        tally_and_finish();
    end
endmodule // testbench
